/* src/brmcd_pkg.sv */
package brmcd_pkg;
    localparam logic [2:0] CMD_TYPE_CTRL   = 3'h0;
    localparam logic [5:0] OP_PT_UPDATE    = 6'h23;
    localparam logic [5:0] OP_SW_NOTIFY    = 6'h02;
    localparam logic [5:0] OP_STALL        = 6'h03;
    localparam int         TYPE_HI         = 31;
    localparam int         TYPE_LO         = 29;
    localparam int         OP_HI           = 28;
    localparam int         OP_LO           = 23;
    localparam int         GLOBAL_BIT      = 22;
    localparam int         LEN_HI          = 5;
    localparam int         LEN_LO          = 0;
    localparam int         ADDR_HI         = 31;
    localparam int         ADDR_LO         = 12;
    localparam int         SPR_C_BIT       = 20;
    localparam int         CC_HI           = 19;
    localparam int         CC_LO           = 16;
    localparam int         PLN_C_BIT       = 15;
    localparam int         SPR_B_BIT       = 10;
    localparam int         PLN_B_BIT       = 9;
    localparam logic [3:0] CC_DISABLED     = 4'h0;
    localparam logic [3:0] CC_MAX_ENABLED  = 4'h5;
    localparam logic [5:0] LEN_ONE_ENTRY   = 6'h00;
    localparam logic [19:0] ADDR_ONE       = 20'h00001;

    typedef struct packed {
        logic [31:0] data;
        logic        valid;
        logic        from_batch;
        logic        privileged;
        logic        primary_ring;
    } brmcd_dw_t;

    typedef struct packed {
        logic        valid;
        logic [19:0] index;
        logic [31:0] data;
    } brmcd_pte_wr_t;

    typedef struct packed {
        logic sprite_c;
        logic plane_c;
        logic sprite_b;
        logic plane_b;
    } brmcd_flip_t;

    typedef enum logic [1:0] {
        ST_HEADER = 2'b00,
        ST_ADDR   = 2'b01,
        ST_DATA   = 2'b11,
        ST_STALL  = 2'b10
    } brmcd_state_t;
endpackage

/* src/brmcd_top.sv */
// Contract
// - page-table update opcode 23h writes entries in order
// - page-table update accepted only when privileged
// - length field is data dword count minus one
// - dword 1 bits 31:12 give first entry
// - each data dword becomes one entry
// - notify opcode 02h pulses interrupt, no stall
// - stall opcode 03h waits while condition holds
// - batch stall halts parser and arbitration
// - ring stall stops only that ring
// - inactive condition makes stall a no-op
// - primary ring stall yields its time slice
// - bits 20 and 10 select sprite flips
// - flip stall holds until flip completes
// - code select 1h-5h waits until code clears
`timescale 1ns/1ps
`default_nettype none
module brmcd_top
(
    input  wire logic                   i_clk_sys,
    input  wire logic                   i_rst,
    input  wire brmcd_pkg::brmcd_dw_t   i_dw,
    output logic                        o_dw_ready,
    input  wire brmcd_pkg::brmcd_flip_t i_flip_pending,
    input  wire logic [14:0]            i_cond_codes,
    output brmcd_pkg::brmcd_pte_wr_t    o_pte_wr,
    output logic                        o_user_irq,
    output logic                        o_priv_violation,
    output logic                        o_ring_stalled,
    output logic                        o_arb_suspend,
    output logic                        o_yield_slice,
    output logic                        o_cmd_done
);
    // ------------------------------------------------------------
    // synchronise off-domain condition inputs
    // ------------------------------------------------------------
    brmcd_pkg::brmcd_flip_t flip_s1_r;
    brmcd_pkg::brmcd_flip_t flip_s2_r;
    logic [14:0]            cc_s1_r;
    logic [14:0]            cc_s2_r;

    always_ff @(posedge i_clk_sys)
    begin
        flip_s1_r <= i_flip_pending;
        flip_s2_r <= flip_s1_r;
        cc_s1_r   <= i_cond_codes;
        cc_s2_r   <= cc_s1_r;
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    brmcd_pkg::brmcd_state_t state_r;
    brmcd_pkg::brmcd_state_t state_nxt;
    logic [5:0]              left_r;
    logic [5:0]              left_nxt;
    logic [19:0]             idx_r;
    logic [19:0]             idx_nxt;
    logic [31:0]             hdr_r;
    logic                    batch_r;
    logic                    primary_r;
    logic                    first_chk_r;
    logic                    cond_active;

    // ------------------------------------------------------------
    // header decode
    // ------------------------------------------------------------
    logic       take;
    logic       is_ctrl;
    logic       hdr_ok;
    logic [5:0] opcode;
    logic       op_pt;
    logic       op_notify;
    logic       op_stall;

    assign o_dw_ready = (state_r != brmcd_pkg::ST_STALL);
    assign take   = i_dw.valid && o_dw_ready;
    assign is_ctrl = i_dw.data[brmcd_pkg::TYPE_HI:brmcd_pkg::TYPE_LO]
                     == brmcd_pkg::CMD_TYPE_CTRL;
    assign opcode = i_dw.data[brmcd_pkg::OP_HI:brmcd_pkg::OP_LO];
    assign hdr_ok = take && state_r == brmcd_pkg::ST_HEADER && is_ctrl;
    assign op_pt  = hdr_ok && opcode == brmcd_pkg::OP_PT_UPDATE;
    assign op_notify = hdr_ok && opcode == brmcd_pkg::OP_SW_NOTIFY;
    assign op_stall = hdr_ok && opcode == brmcd_pkg::OP_STALL;

    brmcd_wait_eval u_wait_eval
    (
        .i_clk_sys      (i_clk_sys),
        .i_rst          (i_rst),
        .i_header       (hdr_r),
        .i_flip_pending (flip_s2_r),
        .i_cond_codes   (cc_s2_r),
        .o_active       (cond_active)
    );

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        state_nxt = state_r;
        left_nxt  = left_r;
        idx_nxt   = idx_r;
        case (state_r)
            brmcd_pkg::ST_HEADER:
            begin
                if (op_pt && i_dw.privileged)
                begin
                    state_nxt = brmcd_pkg::ST_ADDR;
                    left_nxt  = i_dw.data[brmcd_pkg::LEN_HI:
                                          brmcd_pkg::LEN_LO];
                end
                else if (op_stall)
                    state_nxt = brmcd_pkg::ST_STALL;
            end
            brmcd_pkg::ST_ADDR:
            begin
                if (take)
                begin
                    idx_nxt = i_dw.data[brmcd_pkg::ADDR_HI:
                                        brmcd_pkg::ADDR_LO];
                    state_nxt = brmcd_pkg::ST_DATA;
                end
            end
            brmcd_pkg::ST_DATA:
            begin
                if (take)
                begin
                    idx_nxt = idx_r + brmcd_pkg::ADDR_ONE;
                    left_nxt = left_r - 6'h01;
                    if (left_r == brmcd_pkg::LEN_ONE_ENTRY)
                        state_nxt = brmcd_pkg::ST_HEADER;
                end
            end
            brmcd_pkg::ST_STALL:
            begin
                if (!cond_active)
                    state_nxt = brmcd_pkg::ST_HEADER;
            end
            default:
                state_nxt = brmcd_pkg::ST_HEADER;
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            state_r     <= brmcd_pkg::ST_HEADER;
            left_r      <= brmcd_pkg::LEN_ONE_ENTRY;
            idx_r       <= '0;
            hdr_r       <= '0;
            batch_r     <= 1'b0;
            primary_r   <= 1'b0;
            first_chk_r <= 1'b0;
        end
        else
        begin
            state_r     <= state_nxt;
            left_r      <= left_nxt;
            idx_r       <= idx_nxt;
            first_chk_r <= op_stall;
            if (op_stall)
            begin
                hdr_r     <= i_dw.data;
                batch_r   <= i_dw.from_batch;
                primary_r <= i_dw.primary_ring;
            end
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    logic stalling;
    logic pte_fire;

    assign stalling = (state_r == brmcd_pkg::ST_STALL) && cond_active;
    assign pte_fire = take && state_r == brmcd_pkg::ST_DATA;

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            o_pte_wr         <= '0;
            o_user_irq       <= 1'b0;
            o_priv_violation <= 1'b0;
            o_ring_stalled   <= 1'b0;
            o_arb_suspend    <= 1'b0;
            o_yield_slice    <= 1'b0;
            o_cmd_done       <= 1'b0;
        end
        else
        begin
            o_pte_wr.valid   <= pte_fire;
            o_pte_wr.index   <= idx_r;
            o_pte_wr.data    <= i_dw.data;
            o_user_irq       <= op_notify;
            o_priv_violation <= op_pt && !i_dw.privileged;
            o_ring_stalled   <= stalling && !batch_r;
            o_arb_suspend    <= stalling && batch_r;
            o_yield_slice    <= stalling && first_chk_r
                                && !batch_r && primary_r;
            o_cmd_done       <= (state_r == brmcd_pkg::ST_STALL
                                 && !cond_active)
                                || op_notify
                                || (pte_fire && left_r
                                    == brmcd_pkg::LEN_ONE_ENTRY);
        end
    end

    AST_NOTIFY_PULSE: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        op_notify |=> o_user_irq && o_dw_ready)
        else $error("notify did not pulse or stalled");
    AST_PRIV_BLOCK: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        op_pt && !i_dw.privileged |=> state_r == brmcd_pkg::ST_HEADER
        && o_priv_violation)
        else $error("unprivileged update accepted");
    AST_UPD_ENTER: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        op_pt && i_dw.privileged |=> state_r == brmcd_pkg::ST_ADDR)
        else $error("update header not accepted");
    AST_ENTRY_IDX: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        state_r == brmcd_pkg::ST_ADDR && take |=> idx_r ==
        $past(i_dw.data[brmcd_pkg::ADDR_HI:brmcd_pkg::ADDR_LO]))
        else $error("entry index not captured");
    AST_PTE_WRITE: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        pte_fire |=> o_pte_wr.valid && o_pte_wr.data == $past(i_dw.data)
        && o_pte_wr.index == $past(idx_r))
        else $error("entry write mismatch");
    AST_LEN_END: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        pte_fire && left_r == brmcd_pkg::LEN_ONE_ENTRY
        |=> state_r == brmcd_pkg::ST_HEADER)
        else $error("update length wrong");
    AST_STALL_HOLD: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        stalling |=> state_r == brmcd_pkg::ST_STALL && !o_dw_ready)
        else $error("stall released while condition active");
    AST_NOOP: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        state_r == brmcd_pkg::ST_STALL && !cond_active
        |=> state_r == brmcd_pkg::ST_HEADER ##1 !o_ring_stalled
        && !o_arb_suspend)
        else $error("inactive condition did not pass");
    AST_BATCH_ARB: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        stalling && batch_r |=> o_arb_suspend && !o_ring_stalled)
        else $error("batch stall did not suspend arbitration");
    AST_RING_ONLY: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        stalling && !batch_r |=> o_ring_stalled && !o_arb_suspend)
        else $error("ring stall suspended arbitration");
    AST_YIELD: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        o_yield_slice |-> $past(primary_r) && o_ring_stalled)
        else $error("yield without primary ring stall");
endmodule
`default_nettype wire

/* src/brmcd_wait_eval.sv */
`timescale 1ns/1ps
`default_nettype none
module brmcd_wait_eval
(
    input  wire logic               i_clk_sys,
    input  wire logic               i_rst,
    input  wire logic [31:0]        i_header,
    input  wire brmcd_pkg::brmcd_flip_t i_flip_pending,
    input  wire logic [14:0]        i_cond_codes,
    output logic                    o_active
);
    // ------------------------------------------------------------
    // selected condition, evaluated live
    // ------------------------------------------------------------
    logic [3:0] cc_sel;
    logic       cc_en;
    logic       cc_hit;
    logic       flip_hit;

    assign cc_sel = i_header[brmcd_pkg::CC_HI:brmcd_pkg::CC_LO];
    assign cc_en  = (cc_sel != brmcd_pkg::CC_DISABLED)
                  && (cc_sel <= brmcd_pkg::CC_MAX_ENABLED);
    assign cc_hit = cc_en && i_cond_codes[4'(cc_sel - 4'h1)];
    assign flip_hit =
        (i_header[brmcd_pkg::SPR_C_BIT] && i_flip_pending.sprite_c)
        || (i_header[brmcd_pkg::SPR_B_BIT] && i_flip_pending.sprite_b)
        || (i_header[brmcd_pkg::PLN_C_BIT] && i_flip_pending.plane_c)
        || (i_header[brmcd_pkg::PLN_B_BIT] && i_flip_pending.plane_b);
    assign o_active = flip_hit || cc_hit;

    AST_CC_OFF: assert property (
        @(posedge i_clk_sys) disable iff (i_rst)
        (cc_sel == brmcd_pkg::CC_DISABLED) && !flip_hit |-> !o_active)
        else $error("disabled code select still active");
endmodule
`default_nettype wire

/* tb/brmcd_sw_model.sv */
`timescale 1ns/1ps
`default_nettype none
module brmcd_sw_model
(
    input  wire logic                i_clk_sys,
    input  wire logic                i_dw_ready,
    output var brmcd_pkg::brmcd_dw_t o_dw
);
    initial o_dw <= '0;
    // ------------------------------------------------------------
    // dword held until taken at a ready edge
    // ------------------------------------------------------------
    task automatic put(input logic [31:0] d, input logic b,
                       input logic p, input logic pr);
        o_dw <= '{data: d, valid: 1'b1, from_batch: b,
                  privileged: p, primary_ring: pr};
        @(negedge i_clk_sys);
        while (i_dw_ready !== 1'b1)
            @(negedge i_clk_sys);
        @(posedge i_clk_sys);
    endtask
    // released data lines show the inverse of the last value, flags go low
    task automatic idle();
        o_dw <= '{data: ~o_dw.data, valid: 1'b0, from_batch: 1'b0,
                  privileged: 1'b0, primary_ring: 1'b0};
    endtask
    // nothing in flight ahead of an update, so no flush needed
    task automatic update(input logic [19:0] idx, input int n,
                          input logic [31:0] d0, input logic p);
        logic [31:0] h;
        h = '0;
        h[brmcd_pkg::OP_HI:brmcd_pkg::OP_LO] = brmcd_pkg::OP_PT_UPDATE;
        h[brmcd_pkg::GLOBAL_BIT] = 1'b1;
        h[5:0] = 6'(n - 1);
        put(h, 1'b0, p, 1'b1);
        if (p)
        begin
            put({idx, 12'h000}, 1'b0, p, 1'b1);
            for (int k = 0; k < n; k++)
                put(d0 + 32'(k), 1'b0, p, 1'b1);
        end
    endtask
    // one condition per stall header, codes 1..5 only
    // no immediate register loads issued around stalls
    task automatic stall(input logic [31:0] sel, input logic b,
                         input logic pr);
        logic [31:0] h;
        h = sel;
        h[brmcd_pkg::OP_HI:brmcd_pkg::OP_LO] = brmcd_pkg::OP_STALL;
        put(h, b, 1'b1, pr);
        idle();
    endtask
endmodule
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic                     clk;
    logic                     rst;
    brmcd_pkg::brmcd_dw_t     dw;
    logic                     rdy;
    brmcd_pkg::brmcd_flip_t   flip;
    logic [14:0]              cc;
    brmcd_pkg::brmcd_pte_wr_t pte;
    logic                     irq, pv, ring, arb, yld, done;
    int                       mismatches, checks_done, cycles;
    int                       irq_n, pv_n, yld_n, done_n, ring_n, arb_n;
    int                       nr_n, d0, a0, r0, y0;
    logic [51:0]              wr_q[$];
    logic [63:0]              exp_v;
    int                       fb[4];

    brmcd_top dut_u (.i_clk_sys(clk), .i_rst(rst), .i_dw(dw),
        .o_dw_ready(rdy), .i_flip_pending(flip), .i_cond_codes(cc),
        .o_pte_wr(pte), .o_user_irq(irq), .o_priv_violation(pv),
        .o_ring_stalled(ring), .o_arb_suspend(arb),
        .o_yield_slice(yld), .o_cmd_done(done));
    brmcd_sw_model sw_u (.i_clk_sys(clk), .i_dw_ready(rdy), .o_dw(dw));

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // ------------------------------------------------------------
    // output monitor and hang guard
    // ------------------------------------------------------------
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (pte.valid === 1'b1)
            wr_q.push_back({pte.index, pte.data});
        irq_n  <= irq_n + int'(irq === 1'b1);
        pv_n   <= pv_n + int'(pv === 1'b1);
        yld_n  <= yld_n + int'(yld === 1'b1);
        done_n <= done_n + int'(done === 1'b1);
        ring_n <= ring_n + int'(ring === 1'b1);
        arb_n  <= arb_n + int'(arb === 1'b1);
        nr_n   <= nr_n + int'(rdy !== 1'b1 && !rst);
        if (cycles == 5000)
        begin
            mismatches++;
            final_report();
        end
    end
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask
    task automatic snap();
        d0 = done_n;
        a0 = arb_n;
        r0 = ring_n;
        y0 = yld_n;
    endtask
    task automatic wait_done(input int lim);
        for (int i = 0; i < lim && done_n == d0; i++)
            @(posedge clk);
        check(64'(done_n - d0), 64'h1);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial
    begin
        rst = 1'b1;
        flip = '0;
        cc = '0;
        fb = '{brmcd_pkg::SPR_C_BIT, brmcd_pkg::PLN_C_BIT,
               brmcd_pkg::SPR_B_BIT, brmcd_pkg::PLN_B_BIT};
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        // back-to-back updates and notifies
        sw_u.update(20'hFFFFC, 3, 32'h1234_5600, 1'b1);
        sw_u.update(20'h00040, 1, 32'hCAFE_0000, 1'b1);
        sw_u.put({3'h0, brmcd_pkg::OP_SW_NOTIFY, 23'h0}, 1'b0, 1'b1, 1'b1);
        sw_u.put({3'h0, brmcd_pkg::OP_SW_NOTIFY, 23'h0}, 1'b1, 1'b0, 1'b0);
        sw_u.idle();
        repeat (4) @(posedge clk);
        check(64'(wr_q.size()), 64'h4);
        for (int k = 0; k < 3; k++)
        begin
            exp_v = {12'h0, 20'hFFFFC + 20'(k), 32'h1234_5600 + 32'(k)};
            check(64'(wr_q[k]), exp_v);
        end
        check(64'(wr_q[3]), {12'h0, 20'h00040, 32'hCAFE_0000});
        check(64'(irq_n), 64'h2);
        check(64'(done_n), 64'h4);
        check(64'(nr_n), 64'h0);
        // unprivileged update dropped
        sw_u.update(20'h00100, 1, 32'h0, 1'b0);
        sw_u.idle();
        repeat (4) @(posedge clk);
        check(64'(pv_n), 64'h1);
        check(64'(wr_q.size()), 64'h4);
        // inactive condition is a no-op
        snap();
        sw_u.stall(32'h3 << brmcd_pkg::CC_LO, 1'b1, 1'b0);
        wait_done(6);
        check(64'(arb_n - a0), 64'h0);
        // condition codes 1..5 from a batch
        for (int k = 1; k <= 5; k++)
        begin
            cc <= 15'h0001 << (k - 1);
            repeat (4) @(posedge clk);
            snap();
            sw_u.stall(32'(k) << brmcd_pkg::CC_LO, 1'b1, 1'b1);
            repeat (12) @(posedge clk);
            check(64'(done_n - d0), 64'h0);
            check(64'(arb_n - a0 >= 10), 64'h1);
            check(64'(ring_n - r0), 64'h0);
            check(64'(yld_n - y0), 64'h0);
            cc <= '0;
            wait_done(10);
        end
        // flip waits from a primary ring
        for (int k = 0; k < 4; k++)
        begin
            flip <= 4'b1000 >> k;
            repeat (4) @(posedge clk);
            snap();
            sw_u.stall(32'h1 << fb[k], 1'b0, 1'b1);
            repeat (12) @(posedge clk);
            check(64'(ring_n - r0 >= 10), 64'h1);
            check(64'(arb_n - a0), 64'h0);
            check(64'(yld_n - y0), 64'h1);
            flip <= '0;
            wait_done(10);
        end
        final_report();
    end
endmodule
`default_nettype wire
